// ---- dv/ctrl_model.sv ----
`timescale 1ns/100ps
// Memory controller model driving clock enable, command and address pins
module ctrl_model #(
    parameter int WAIT_CYC = 20
) (
    input wire logic                 clk,
    output sdram_init_pkg::cmd_pins_t pins
);
    // termination held static, nominal termination unused
    initial pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 14'h2a5a, 1'b1};

    // Issue one command for one cycle, then deselect with flipped address
    task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
        @(negedge clk);
        pins = '{pins.cke, c[3], c[2], c[1], c[0], ba, a, pins.term_ctrl_in};
        @(negedge clk);
        pins = '{pins.cke, 1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a, pins.term_ctrl_in};
    endtask : cmd

    // clock enable low ahead of reset
    task automatic cke_low();
        pins.cke = 1'b0;
    endtask : cke_low

    // nop, counted wait, clock enable, exit wait
    task automatic power_up();
        cmd(4'h7, 3'h0, 14'h0);
        repeat (WAIT_CYC) @(negedge clk);
        pins.cke = 1'b1;
        repeat (5) @(negedge clk);
    endtask : power_up

    // whole word, test mode off, cycle time spacing
    task automatic mode_reg_set_cmd(input logic [1:0] sel, input logic [13:0] w);
        cmd(4'h0, {1'b0, sel}, {w[13:8], 1'b0, w[6:0]});
        repeat (4) @(negedge clk);
    endtask : mode_reg_set_cmd

    // registers two, three, one with dll enabled
    task automatic load_others();
        mode_reg_set_cmd(2'h2, 14'h0);
        mode_reg_set_cmd(2'h3, 14'h0);
        mode_reg_set_cmd(2'h1, 14'h0);
    endtask : load_others

    task automatic cal_long();
        repeat (12) @(negedge clk);
        cmd(4'h6, 3'h0, 14'h0400);
    endtask : cal_long
endmodule : ctrl_model

// ---- dv/sdram_init_mr0_props.sv ----
`timescale 1ns/100ps
// Pin-level checks for the init and mode register zero block
module sdram_init_mr0_props #(
    parameter int INT_INIT_CYCLES = 20
) (
    input wire logic                        clk,
    input wire logic                        arst_n,
    input wire logic                        cke,
    input wire logic                        cs_n,
    input wire logic                        ras_n,
    input wire logic                        cas_n,
    input wire logic                        we_n,
    input wire logic [2:0]                  bank_select_bits,
    input wire logic [13:0]                 addr,
    input wire logic                        term_ctrl_in,
    input wire logic                        term_enable,
    input wire logic                        init_internal_done,
    input wire logic                        cke_seen,
    input wire logic                        ready,
    input wire logic                        mode_update_busy,
    input wire logic                        dll_reset_pending,
    input wire logic                        dll_locked,
    input wire logic                        cal_done,
    input wire sdram_init_pkg::mr0_fields_t mr0_fields
);
    logic [15:0] since_reg;
    logic [15:0] since_next;
    wire logic   set_cmd = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n & ~bank_select_bits[2];
    wire logic   set_zero = set_cmd & (bank_select_bits[1:0] == 2'h0);

    // Saturating count of edges since reset release
    always_comb since_next = (since_reg == 16'hffff) ? since_reg : since_reg + 16'h1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) since_reg <= 16'h0;
        else since_reg <= since_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_init_wait: assert property (
        init_internal_done |-> since_reg >= 16'(INT_INIT_CYCLES - 2))
        else $error("internal init finished too early");
    a_term_gated: assert property (
        !cke_seen |-> !term_enable)
        else $error("termination on before clock enable seen");
    a_set_busy: assert property (
        set_cmd && cke_seen |-> ##3 mode_update_busy)
        else $error("mode set did not start busy window");
    a_busy_stands: assert property (
        $rose(mode_update_busy) |-> mode_update_busy [*8])
        else $error("busy window too short");
    a_dll_request: assert property (
        set_zero && addr[8] && cke_seen |-> ##3 dll_reset_pending)
        else $error("dll reset request not taken");
    a_dll_self_clear: assert property (
        $rose(dll_reset_pending) |-> ##[500:530] !dll_reset_pending)
        else $error("dll reset bit did not clear in time");
    a_fields_load: assert property (
        set_zero && cke_seen |-> ##5 (mr0_fields.burst_len_field == $past(addr[1:0], 5)
            && mr0_fields.read_burst_order == $past(addr[3], 5)
            && mr0_fields.powerdown_exit_select == $past(addr[12], 5)))
        else $error("register zero fields do not follow written word");
    a_recovery_max: assert property (
        set_zero && cke_seen && addr[11:9] == 3'h0 |-> ##5 mr0_fields.write_recovery == 5'h10)
        else $error("write recovery code zero not sixteen");
    a_ready_locked: assert property (
        ready |-> !dll_reset_pending && cal_done)
        else $error("ready while dll reset pending");
endmodule : sdram_init_mr0_props

bind sdram_init_mr0 sdram_init_mr0_props #(.INT_INIT_CYCLES(INT_INIT_CYCLES)) i_props (
    .clk(clk), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_bits(bank_select_bits), .addr(addr),
    .term_ctrl_in(term_ctrl_in), .term_enable(term_enable),
    .init_internal_done(init_internal_done), .cke_seen(cke_seen), .ready(ready),
    .mode_update_busy(mode_update_busy), .dll_reset_pending(dll_reset_pending),
    .dll_locked(dll_locked), .cal_done(cal_done), .mr0_fields(mr0_fields));

// ---- dv/sdram_init_mr0_tb.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module sdram_init_mr0_tb;
    localparam int         INIT_CYC = 20;
    localparam logic [4:0] WR_TBL [8] = '{5'h10, 5'h5, 5'h6, 5'h7, 5'h8, 5'ha, 5'hc, 5'he};
    logic                        clk;
    logic                        arst_n;
    sdram_init_pkg::cmd_pins_t   pins;
    logic                        term_enable, init_internal_done, cke_seen, ready;
    logic                        mode_update_busy, dll_reset_pending, dll_locked, cal_done;
    sdram_init_pkg::mr0_fields_t mr0_fields;
    int                          num_errors = 0;
    int                          checked = 0;

    sdram_init_mr0 #(.INT_INIT_CYCLES(INIT_CYC)) i_sdram_init_mr0 (
        .clk(clk), .arst_n(arst_n), .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .bank_select_bits(pins.bank_select_bits),
        .addr(pins.addr), .term_ctrl_in(pins.term_ctrl_in), .term_enable(term_enable),
        .init_internal_done(init_internal_done), .cke_seen(cke_seen), .ready(ready),
        .mode_update_busy(mode_update_busy), .dll_reset_pending(dll_reset_pending),
        .dll_locked(dll_locked), .cal_done(cal_done), .mr0_fields(mr0_fields));
    ctrl_model #(.WAIT_CYC(INIT_CYC)) i_ctrl_model (.clk(clk), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1) begin
            if (n == lim) begin
                num_errors++;
                end_sim();
            end
            @(negedge clk);
            n++;
        end
    endtask : wait_hi

    function automatic logic [4:0] exp_cl(input logic hi, input logic [2:0] c);
        if (!hi) return (c == 3'h0) ? 5'h0 : 5'(c) + 5'h4;
        return (c > 3'h4) ? 5'h0 : 5'(c) + 5'hc;
    endfunction : exp_cl

    task automatic check_fields(input logic [13:0] w);
        sdram_init_pkg::mr0_fields_t ex;
        repeat (2) @(negedge clk);
        ex = '{w[1:0], w[1:0] == 2'h3, w[3], exp_cl(w[2], w[6:4]),
               exp_cl(w[2], w[6:4]) == 5'h0, WR_TBL[w[11:9]], w[7], w[12], w[13]};
        `CHK("mr0_fields", ex, mr0_fields)
    endtask : check_fields

    task automatic t_reset(input int n);
        i_ctrl_model.cke_low();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (n) @(negedge clk);
        `CHK("ready", 1'b0, ready)
        `CHK("term_enable", 1'b0, term_enable)
        arst_n = 1'b1;
    endtask : t_reset

    task automatic t_power_up();
        wait_hi(init_internal_done, INIT_CYC + 6);
        `CHK("term_enable", 1'b0, term_enable)
        `CHK("cke_seen", 1'b0, cke_seen)
        i_ctrl_model.power_up();
        wait_hi(cke_seen, 8);
        @(negedge clk);
        `CHK("term_enable", 1'b1, term_enable)
    endtask : t_power_up

    task automatic t_mode_load();
        int n;
        i_ctrl_model.load_others();
        i_ctrl_model.mode_reg_set_cmd(2'h0, 14'h1b39);
        `CHK("busy", 1'b1, mode_update_busy)
        `CHK("dll_pending", 1'b1, dll_reset_pending)
        check_fields(14'h1b39);
        n = 0;
        while (dll_reset_pending === 1'b1 && n < 700) begin
            @(negedge clk);
            n++;
        end
        `CHK("dll_clear", 1'b1, n > 490 && n < 520)
    endtask : t_mode_load

    task automatic t_cal();
        i_ctrl_model.cal_long();
        `CHK("ready", 1'b0, ready)
        wait_hi(ready, 1200);
        `CHK("dll_locked", 1'b1, dll_locked)
        `CHK("cal_done", 1'b1, cal_done)
    endtask : t_cal

    task automatic t_decode();
        logic [3:0]  k;
        logic [13:0] w;
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            w = {1'b0, k[3], k[2:0], 2'h0, k[2:0], k[0], k[3], k[1:0]};
            i_ctrl_model.mode_reg_set_cmd(2'h0, w);
            check_fields(w);
        end
    endtask : t_decode

    initial begin
        arst_n = 1'b0;
        t_reset(10);
        t_power_up();
        t_mode_load();
        t_cal();
        t_decode();
        t_reset(3);
        t_power_up();
        t_mode_load();
        end_sim();
    end
endmodule : sdram_init_mr0_tb

// ---- rtl/mode_reg_store.sv ----
`timescale 1ns/100ps
// Four mode registers with registered read port
module mode_reg_store (
    input  wire logic                                 clk,
    input  wire logic                                 arst_n,
    input  wire logic                                 wr_en,
    input  wire logic [1:0]                           wr_sel,
    input  wire logic [sdram_init_pkg::MR_WIDTH-1:0]  wr_data,
    input  wire logic [1:0]                           rd_sel,
    output logic      [sdram_init_pkg::MR_WIDTH-1:0]  rd_data
);

    logic [sdram_init_pkg::MR_WIDTH-1:0] mem_reg  [sdram_init_pkg::MR_COUNT];
    logic [sdram_init_pkg::MR_WIDTH-1:0] mem_next [sdram_init_pkg::MR_COUNT];
    logic [sdram_init_pkg::MR_WIDTH-1:0] rd_next;

    // Whole word replaced on every write
    always_comb begin
        for (int i = 0; i < sdram_init_pkg::MR_COUNT; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en) begin
            mem_next[wr_sel] = wr_data;
        end
        rd_next = mem_reg[rd_sel];
    end

    // Storage and read register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < sdram_init_pkg::MR_COUNT; i++) begin
                mem_reg[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            for (int i = 0; i < sdram_init_pkg::MR_COUNT; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rd_data <= rd_next;
        end
    end

endmodule : mode_reg_store

// ---- rtl/sdram_init_mr0.sv ----
`timescale 1ns/100ps
module sdram_init_mr0 #(
    parameter int INT_INIT_CYCLES = sdram_init_pkg::INT_INIT_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          cke,
    input  wire logic                          cs_n,
    input  wire logic                          ras_n,
    input  wire logic                          cas_n,
    input  wire logic                          we_n,
    input  wire logic [2:0]                    bank_select_bits,
    input  wire logic [13:0]                   addr,
    input  wire logic                          term_ctrl_in,
    output logic                               term_enable,
    output logic                               init_internal_done,
    output logic                               cke_seen,
    output logic                               ready,
    output logic                               mode_update_busy,
    output logic                               dll_reset_pending,
    output logic                               dll_locked,
    output logic                               cal_done,
    output sdram_init_pkg::mr0_fields_t        mr0_fields
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Latency code to cycles, zero when reserved
    function automatic logic [4:0] latency_cycles(input logic [2:0] code, input logic hi);
        logic [4:0] res;
        res = 5'h00;
        if (!hi && code != 3'h0) begin
            res = 5'(code) + 5'h04;
        end else if (hi && code <= 3'h4) begin
            res = 5'(code) + 5'h0c;
        end
        return res;
    endfunction : latency_cycles

    // Write recovery code to cycles
    function automatic logic [4:0] wr_cycles(input logic [2:0] code);
        logic [4:0] res;
        res = 5'h10;
        if (code >= 3'h1 && code <= 3'h4) begin
            res = 5'(code) + 5'h04;
        end else if (code >= 3'h5) begin
            res = 5'({code, 1'b0});
        end
        return res;
    endfunction : wr_cycles

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    sdram_init_pkg::cmd_pins_t pins_raw;
    sdram_init_pkg::cmd_pins_t meta_reg;
    sdram_init_pkg::cmd_pins_t pins_reg;

    assign pins_raw = '{cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr, term_ctrl_in};

    // Two stage capture of controller pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000, 1'b0};
            pins_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000, 1'b0};
        end else begin
            meta_reg <= pins_raw;
            pins_reg <= meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    logic cmd_live;
    logic is_mrs;
    logic is_cal_long;

    assign cmd_live = pins_reg.cke && !pins_reg.cs_n;
    // [R18] Mode set decode
    assign is_mrs = cmd_live && !pins_reg.ras_n && !pins_reg.cas_n && !pins_reg.we_n
                    && !pins_reg.bank_select_bits[2];
    assign is_cal_long = cmd_live && pins_reg.ras_n && pins_reg.cas_n && !pins_reg.we_n
                         && pins_reg.addr[sdram_init_pkg::CAL_LONG_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Initialisation sequencer and timers

    sdram_init_pkg::init_state_t state_reg, state_next;
    logic [13:0] init_cnt_reg, init_cnt_next;
    logic [9:0]  dll_cnt_reg,  dll_cnt_next;
    logic [9:0]  cal_cnt_reg,  cal_cnt_next;
    logic [4:0]  mod_cnt_reg,  mod_cnt_next;
    logic        dll_rst_reg,  dll_rst_next;
    logic        accept_mrs;
    logic        mrs_zero_dll;

    assign accept_mrs   = is_mrs && (state_reg == sdram_init_pkg::ST_CONFIG
                                     || state_reg == sdram_init_pkg::ST_CALIBRATE
                                     || state_reg == sdram_init_pkg::ST_READY);
    assign mrs_zero_dll = accept_mrs && pins_reg.bank_select_bits[1:0] == sdram_init_pkg::MR_ZERO
                          && pins_reg.addr[sdram_init_pkg::DLL_RST_BIT];

    // Next state and counters
    always_comb begin
        state_next    = state_reg;
        init_cnt_next = init_cnt_reg;
        dll_cnt_next  = dll_cnt_reg;
        cal_cnt_next  = cal_cnt_reg;
        mod_cnt_next  = mod_cnt_reg;
        dll_rst_next  = dll_rst_reg;
        unique case (state_reg)
            // [R3] Internal init without clock enable
            sdram_init_pkg::ST_INTERNAL: begin
                if (init_cnt_reg == 14'(INT_INIT_CYCLES - 1)) begin
                    state_next = sdram_init_pkg::ST_WAIT_CKE;
                end else begin
                    init_cnt_next = init_cnt_reg + 14'h0001;
                end
            end
            sdram_init_pkg::ST_WAIT_CKE: begin
                if (pins_reg.cke) begin
                    state_next = sdram_init_pkg::ST_CONFIG;
                end
            end
            sdram_init_pkg::ST_CONFIG: begin
                if (is_cal_long) begin
                    state_next   = sdram_init_pkg::ST_CALIBRATE;
                    cal_cnt_next = 10'h000;
                end
            end
            sdram_init_pkg::ST_CALIBRATE: begin
                if (cal_cnt_reg != 10'(sdram_init_pkg::INIT_CAL_CYC)) begin
                    cal_cnt_next = cal_cnt_reg + 10'h001;
                end else if (!dll_rst_reg) begin
                    state_next = sdram_init_pkg::ST_READY;
                end
            end
            sdram_init_pkg::ST_READY: begin
            end
        endcase
        // [R15] Feature update window after a mode set
        if (accept_mrs) begin
            mod_cnt_next = 5'(sdram_init_pkg::MOD_TO_CMD_CYC);
        end else if (mod_cnt_reg != 5'h00) begin
            mod_cnt_next = mod_cnt_reg - 5'h01;
        end
        // [R23] DLL reset self clears after lock time, new request wins
        if (mrs_zero_dll) begin
            dll_rst_next = 1'b1;
            dll_cnt_next = 10'h000;
        end else if (dll_rst_reg) begin
            if (dll_cnt_reg == 10'(sdram_init_pkg::DLL_LOCK_CYC - 1)) begin
                dll_rst_next = 1'b0;
            end else begin
                dll_cnt_next = dll_cnt_reg + 10'h001;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= sdram_init_pkg::ST_INTERNAL;
            init_cnt_reg <= 14'h0000;
            dll_cnt_reg  <= 10'h000;
            cal_cnt_reg  <= 10'h000;
            mod_cnt_reg  <= 5'h00;
            dll_rst_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            init_cnt_reg <= init_cnt_next;
            dll_cnt_reg  <= dll_cnt_next;
            cal_cnt_reg  <= cal_cnt_next;
            mod_cnt_reg  <= mod_cnt_next;
            dll_rst_reg  <= dll_rst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register storage

    logic [sdram_init_pkg::MR_WIDTH-1:0] mr0_word;

    // [R13] Full word stored per mode set
    mode_reg_store u_store (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (accept_mrs),
        .wr_sel  (pins_reg.bank_select_bits[1:0]),
        .wr_data (pins_reg.addr),
        .rd_sel  (sdram_init_pkg::MR_ZERO),
        .rd_data (mr0_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    sdram_init_pkg::mr0_fields_t fields_next;
    logic term_next;
    logic cke_seen_next;

    // Field decode of register zero
    always_comb begin
        // [R19] Burst length and order
        fields_next.burst_len_field    = mr0_word[sdram_init_pkg::BL_LSB +: 2];
        fields_next.burst_len_reserved = mr0_word[sdram_init_pkg::BL_LSB +: 2]
                                         == sdram_init_pkg::BL_RESERVED;
        fields_next.read_burst_order   = mr0_word[sdram_init_pkg::RBT_BIT];
        // [R20] Read latency
        fields_next.read_latency       = latency_cycles(mr0_word[sdram_init_pkg::CL_LSB +: 3],
                                                        mr0_word[sdram_init_pkg::CL_LOW_BIT]);
        fields_next.latency_reserved   = fields_next.read_latency == 5'h00;
        // [R21] Write recovery
        fields_next.write_recovery     = wr_cycles(mr0_word[sdram_init_pkg::WR_LSB +: 3]);
        // [R22] Test mode, exit policy, top bit check
        fields_next.test_mode_bit      = mr0_word[sdram_init_pkg::TM_BIT];
        fields_next.powerdown_exit_select = mr0_word[sdram_init_pkg::PPD_BIT];
        fields_next.a13_violation      = mr0_word[sdram_init_pkg::A13_BIT];
        cke_seen_next = state_reg != sdram_init_pkg::ST_INTERNAL
                        && state_reg != sdram_init_pkg::ST_WAIT_CKE;
        // [R7] Termination off until clock enable registered
        term_next = cke_seen_next && pins_reg.term_ctrl_in;
    end

    // Output registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mr0_fields         <= '0;
            term_enable        <= 1'b0;
            cke_seen           <= 1'b0;
            init_internal_done <= 1'b0;
            ready              <= 1'b0;
            mode_update_busy   <= 1'b0;
            dll_reset_pending  <= 1'b0;
            dll_locked         <= 1'b0;
            cal_done           <= 1'b0;
        end else begin
            mr0_fields         <= fields_next;
            term_enable        <= term_next;
            cke_seen           <= cke_seen_next;
            init_internal_done <= state_reg != sdram_init_pkg::ST_INTERNAL;
            ready              <= state_reg == sdram_init_pkg::ST_READY;
            mode_update_busy   <= mod_cnt_next != 5'h00;
            dll_reset_pending  <= dll_rst_next;
            dll_locked         <= !dll_rst_next && cke_seen_next;
            cal_done           <= state_reg == sdram_init_pkg::ST_READY;
        end
    end

endmodule : sdram_init_mr0

// ---- rtl/sdram_init_pkg.sv ----
// Function
// [R1] Controller holds reset low at least 200 us after power is stable.
// [R2] Controller drives clock enable low at least 10 ns before reset release.
// [R3] After reset release wait 500 us; device initialises without the clock.
// [R4] Clock runs stably max(10 ns, 5 cycles) before clock enable rises.
// [R5] Controller registers a NOP or Deselect before first clock enable high.
// [R6] Clock enable stays high from first registration until initialisation ends.
// [R7] Device keeps termination off during reset and until clock enable registered high.
// [R8] Termination control held static after clock enable; low if nominal termination used.
// [R9] Controller waits max(self refresh exit, 5 cycles) before first mode set.
// [R10] Mode registers load in order two, three, one (DLL on), zero (DLL reset).
// [R11] After loading, issue long calibration and wait DLL lock and calibration time.
// [R12] Warm reset: reset low 100 ns, clock enable low first, then resume.
// [R13] Every mode register write supplies all fields; contents undefined after reset.
// [R14] Consecutive mode register writes are spaced by the mode register cycle time.
// [R15] Only NOP or Deselect during mode-to-command time; features update within it.
// [R16] Rewrite mode registers in normal operation only when the device is idle.
// [R17] With nominal termination on, termination control low until mode-to-command time.
// [R18] Mode set is all four command pins low, bank bit two low, bits one:zero select.
// [R19] Bits 1:0 set burst length; bit 3 selects sequential or interleaved order.
// [R20] Latency bits 6:4 with bit 2 give 5..11 or 12..16 cycles, else reserved.
// [R21] Write recovery bits 11:9 map 0 to 16, others 5,6,7,8,10,12,14.
// [R22] Bit 8 DLL reset, bit 7 test mode, bit 12 power-down exit, bit 13 zero.
// [R23] Device clears the DLL reset bit itself once the DLL reset is performed.
// [R24] Controller never programs the test mode bit to one.
// [R25] Controller counts each initialisation wait in cycles, rounded up.
package sdram_init_pkg;

    // Clock and timing
    localparam int CLK_MHZ          = 25;
    localparam int INT_INIT_US      = 500;
    localparam int INT_INIT_CYC     = INT_INIT_US * CLK_MHZ;
    localparam int DLL_LOCK_CYC     = 512;
    localparam int INIT_CAL_CYC     = 512;
    localparam int MOD_TO_CMD_CYC   = 12;

    // Mode register store
    localparam int MR_WIDTH         = 14;
    localparam int MR_COUNT         = 4;
    localparam logic [1:0] MR_ZERO  = 2'h0;

    // Mode register zero field positions and long calibration address bit
    localparam int BL_LSB           = 0;
    localparam int CL_LOW_BIT       = 2;
    localparam int RBT_BIT          = 3;
    localparam int CL_LSB           = 4;
    localparam int TM_BIT           = 7;
    localparam int DLL_RST_BIT      = 8;
    localparam int WR_LSB           = 9;
    localparam int PPD_BIT          = 12;
    localparam int A13_BIT          = 13;
    localparam int CAL_LONG_BIT     = 10;

    // Burst length codes
    localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;
    localparam logic [1:0] BL_FIXED_CHOP  = 2'h2;
    localparam logic [1:0] BL_RESERVED    = 2'h3;

    typedef enum logic [2:0] {
        ST_INTERNAL,
        ST_WAIT_CKE,
        ST_CONFIG,
        ST_CALIBRATE,
        ST_READY
    } init_state_t;

    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  bank_select_bits;
        logic [13:0] addr;
        logic        term_ctrl_in;
    } cmd_pins_t;

    typedef struct packed {
        logic [1:0]  burst_len_field;
        logic        burst_len_reserved;
        logic        read_burst_order;
        logic [4:0]  read_latency;
        logic        latency_reserved;
        logic [4:0]  write_recovery;
        logic        test_mode_bit;
        logic        powerdown_exit_select;
        logic        a13_violation;
    } mr0_fields_t;

endpackage : sdram_init_pkg
